// ### logic/cch_pkg.sv
// Package of constants for the card calibration command handler.
`default_nettype none
package cch_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_ARG = 8'h04;
  localparam logic [7:0] ADDR_CODE_LO = 8'h08;
  localparam logic [7:0] ADDR_CODE_HI = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ERR = 8'h14;
  localparam logic [7:0] ADDR_SRE = 8'h18;
  localparam logic [7:0] ADDR_RESP = 8'h1C;
  localparam logic [7:0] ADDR_RTC = 8'h20;
  localparam logic [7:0] ADDR_CALERR = 8'h24;
  localparam logic [7:0] ADDR_TEMP = 8'h28;
  // Command codes: bits 3:0 opcode, bit 4 selects slot two.
  localparam logic [3:0] OP_CODE = 4'h1;
  localparam logic [3:0] OP_INIT = 4'h2;
  localparam logic [3:0] OP_COUNT_Q = 4'h3;
  localparam logic [3:0] OP_ZERO_CNT = 4'h4;
  localparam logic [3:0] OP_DATE_Q = 4'h5;
  localparam logic [3:0] OP_SAVE = 4'h6;
  localparam logic [3:0] OP_LOCK = 4'h7;
  localparam logic [3:0] OP_LOCK_Q = 4'h8;
  localparam logic [3:0] OP_COLD_STEP = 4'h9;
  localparam int SLOT_BIT = 4;
  // Status byte fields.
  localparam int AVAIL_BIT = 2;
  localparam int RQS_BIT = 6;
  localparam logic [7:0] SRE_RESET = 8'h00;
  // Default passcode, arbitrary.
  localparam logic [63:0] CODE_DEFAULT = 64'h4341_4C30_3030_3030;
  // Error numbers.
  localparam logic [9:0] ERR_DCV_LO = 10'h190;
  localparam logic [9:0] ERR_DCV_HI = 10'h1A9;
  localparam logic [9:0] ERR_NO_DATE = 10'h1B6;
  localparam logic [9:0] ERR_NO_NEXT = 10'h1B7;
  localparam logic [9:0] ERR_AC_LO = 10'h1C2;
  localparam logic [9:0] ERR_AC_HI = 10'h1DB;
  localparam logic [9:0] ERR_COLD = 10'h1DC;
  localparam logic [9:0] ERR_INVALID = 10'h1F4;
  localparam logic [9:0] ERR_AC_LOST = 10'h201;
  localparam logic [9:0] ERR_DC_LOST = 10'h202;
  localparam logic [9:0] ERR_DATES_LOST = 10'h203;
  localparam logic [9:0] ERR_CARD_LOST = 10'h206;
  localparam logic [9:0] ERR_CARD_DATES = 10'h207;
  localparam logic [9:0] ERR_QUESTION = 10'h262;
  localparam logic [9:0] ERR_LOCKED = 10'h262;
  // Temperature limits in whole degrees C for cold calibration.
  localparam logic signed [15:0] COLD_MIN = 16'sh0000;
  localparam logic signed [15:0] COLD_MAX = 16'sh0032;
  localparam int QDEPTH = 8;
  localparam int QAW = 3;
endpackage
`default_nettype wire

// ### logic/cch_err_queue.sv
// Error queue of numbered errors, first in first out.
`default_nettype none
module cch_err_queue (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Push side.
  input wire logic push,
  input wire logic [9:0] push_code,
  // Pop side.
  input wire logic pop,
  output logic [9:0] head_code,
  output logic not_empty
);
  logic [9:0] mem_reg [cch_pkg::QDEPTH];
  logic [cch_pkg::QAW-1:0] wr_reg;
  logic [cch_pkg::QAW-1:0] rd_reg;
  logic [cch_pkg::QAW:0] cnt_reg;
  logic do_push;
  logic do_pop;

  assign do_pop = pop && (cnt_reg != '0);
  assign do_push = push && (cnt_reg != (cch_pkg::QAW+1)'(cch_pkg::QDEPTH));
  assign not_empty = (cnt_reg != '0);
  assign head_code = not_empty ? mem_reg[rd_reg] : 10'h000;

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem_reg[wr_reg] <= push_code;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (cch_pkg::QAW+1)'(do_push)
        - (cch_pkg::QAW+1)'(do_pop);
    end
  end
endmodule // cch_err_queue
`default_nettype wire

// ### logic/cch_handler.sv
// Card calibration command handler with APB registers.
`default_nettype none
// Behaviour
// - Date query for slot one returns that card's year, month, day; slot two returns 0.
// - Calibrating a card stamps its date from the real time clock.
// - Card calibration proceeds only after the passcode has unlocked it.
// - Lock command disables card calibration again.
// - Lock query returns 0 while calibration is locked.
// - Lock query returns 1 while calibration is unlocked.
// - Reset-count command sets the card calibration count to 0.
// - Save writes computed constants into the card nonvolatile store.
// - Without save, new constants stay temporary and are not kept.
// - Cold step calibrates the temperature sensor from the supplied value.
// - DC, resistance and DC current failures report errors 400 to 425.
// - AC failures report errors 450 to 475.
// - Missing date and next date report errors 438 and 439.
// - Invalid data 500, lost AC 513, DC 514, dates 515, questionable 610.
// - Card errors: cold failure 476, lost data 518, lost dates 519.
// - Every error enters the queue unless it already holds eight; error query returns its number.
// - Error-available bit 2 of status byte is set while queue holds errors.
// - Reading an error removes it and updates error-available.
// - With service enable 4, error-available raises a service request.
// - Passcode unlocks only when it equals the default of eight letters or digits.
module cch_handler (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Service request to the bus.
  output logic srq,
  // Card nonvolatile store and cold calibration value.
  output logic nv_write,
  output logic [31:0] nv_data,
  output logic [15:0] cold_temp
);
  logic wr_en;
  logic rd_en;
  logic [4:0] cmd;
  logic [3:0] op;
  logic slot2;
  logic [63:0] code_reg;
  logic unlock_reg;
  logic init_reg;
  logic [15:0] arg_reg;
  logic [31:0] rtc_reg;
  logic [31:0] date_reg [2];
  logic [15:0] count_reg [2];
  logic [31:0] konst_reg;
  logic [31:0] resp_reg;
  logic [7:0] sre_reg;
  logic nv_write_reg;
  logic [31:0] nv_data_reg;
  logic [15:0] cold_reg;
  logic q_push;
  logic [9:0] q_code;
  logic q_pop;
  logic [9:0] q_head;
  logic q_ne;
  logic code_ok;
  logic protected_op;
  logic refuse;
  logic [7:0] stb;
  logic [9:0] ext_code;
  logic ext_ok;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign cmd = pwdata[4:0];
  assign op = cmd[3:0];
  assign slot2 = cmd[cch_pkg::SLOT_BIT];

  // Passcode compare; each byte must be blank, a letter or a digit.
  always_comb begin
    code_ok = (pwdata[31:0] == 32'h0000_0000) ? 1'b0 : 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (!(code_reg[i*8 +: 8] == 8'h00 ||
          (code_reg[i*8 +: 8] >= 8'h30 && code_reg[i*8 +: 8] <= 8'h39) ||
          (code_reg[i*8 +: 8] >= 8'h41 && code_reg[i*8 +: 8] <= 8'h5A) ||
          (code_reg[i*8 +: 8] >= 8'h61 && code_reg[i*8 +: 8] <= 8'h7A))) begin
        code_ok = 1'b0;
      end
    end
    if (code_reg != cch_pkg::CODE_DEFAULT) begin
      code_ok = 1'b0;
    end
  end

  // Protected commands other than queries and passcode need the unlock.
  assign protected_op = (op == cch_pkg::OP_INIT) ||
    (op == cch_pkg::OP_ZERO_CNT) || (op == cch_pkg::OP_SAVE) ||
    (op == cch_pkg::OP_LOCK) || (op == cch_pkg::OP_COLD_STEP);
  assign refuse = protected_op && !unlock_reg;

  // Externally reported failures are accepted only at documented numbers.
  assign ext_code = pwdata[9:0];
  assign ext_ok = (ext_code >= cch_pkg::ERR_DCV_LO &&
      ext_code <= cch_pkg::ERR_DCV_HI) ||
    (ext_code >= cch_pkg::ERR_AC_LO &&
      ext_code <= cch_pkg::ERR_AC_HI) ||
    ext_code == cch_pkg::ERR_NO_DATE ||
    ext_code == cch_pkg::ERR_NO_NEXT ||
    ext_code == cch_pkg::ERR_INVALID || ext_code == cch_pkg::ERR_AC_LOST ||
    ext_code == cch_pkg::ERR_DC_LOST || ext_code == cch_pkg::ERR_DATES_LOST ||
    ext_code == cch_pkg::ERR_QUESTION ||
    ext_code == cch_pkg::ERR_COLD || ext_code == cch_pkg::ERR_CARD_LOST ||
    ext_code == cch_pkg::ERR_CARD_DATES;

  // Error sources feeding the queue.
  always_comb begin
    q_push = 1'b0;
    q_code = 10'h000;
    if (wr_en && paddr == cch_pkg::ADDR_CMD) begin
      if (refuse) begin
        q_push = 1'b1;
        q_code = cch_pkg::ERR_LOCKED;
      end else if (op == cch_pkg::OP_COLD_STEP && !slot2 && init_reg &&
          ($signed(arg_reg) < cch_pkg::COLD_MIN ||
           $signed(arg_reg) > cch_pkg::COLD_MAX)) begin
        q_push = 1'b1;
        q_code = cch_pkg::ERR_COLD;
      end
    end else if (wr_en && paddr == cch_pkg::ADDR_CALERR && ext_ok) begin
      q_push = 1'b1;
      q_code = ext_code;
    end
  end

  assign q_pop = rd_en && paddr == cch_pkg::ADDR_ERR;

  cch_err_queue u_queue (
    .mclk(mclk),
    .rst(rst),
    .push(q_push),
    .push_code(q_code),
    .pop(q_pop),
    .head_code(q_head),
    .not_empty(q_ne)
  );

  // Status byte with error-available and request summary.
  always_comb begin
    stb = 8'h00;
    stb[cch_pkg::AVAIL_BIT] = q_ne;
    stb[cch_pkg::RQS_BIT] = |(stb & sre_reg);
  end
  assign srq = stb[cch_pkg::RQS_BIT];

  // Passcode, argument, time and service enable registers.
  always_ff @(posedge mclk) begin
    if (rst) begin
      code_reg <= 64'h0000_0000_0000_0000;
      arg_reg <= 16'h0000;
      rtc_reg <= 32'h0000_0000;
      sre_reg <= cch_pkg::SRE_RESET;
    end else if (wr_en) begin
      unique case (paddr)
        cch_pkg::ADDR_CODE_LO: code_reg[31:0] <= pwdata;
        cch_pkg::ADDR_CODE_HI: code_reg[63:32] <= pwdata;
        cch_pkg::ADDR_ARG: arg_reg <= pwdata[15:0];
        cch_pkg::ADDR_RTC: rtc_reg <= pwdata;
        cch_pkg::ADDR_SRE: sre_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Unlock and initiate state.
  always_ff @(posedge mclk) begin
    if (rst) begin
      unlock_reg <= 1'b0;
      init_reg <= 1'b0;
    end else if (wr_en && paddr == cch_pkg::ADDR_CMD) begin
      if (op == cch_pkg::OP_CODE && code_ok) begin
        unlock_reg <= 1'b1;
      end else if (op == cch_pkg::OP_LOCK && !refuse) begin
        unlock_reg <= 1'b0;
        init_reg <= 1'b0;
      end else if (op == cch_pkg::OP_INIT && !refuse && !slot2) begin
        init_reg <= 1'b1;
      end
    end
  end

  // Card dates, counts, working constants and nonvolatile write.
  always_ff @(posedge mclk) begin
    if (rst) begin
      date_reg[0] <= 32'h0000_0000;
      date_reg[1] <= 32'h0000_0000;
      count_reg[0] <= 16'h0000;
      count_reg[1] <= 16'h0000;
      konst_reg <= 32'h0000_0000;
      cold_reg <= 16'h0000;
      nv_write_reg <= 1'b0;
      nv_data_reg <= 32'h0000_0000;
    end else begin
      nv_write_reg <= 1'b0;
      if (wr_en && paddr == cch_pkg::ADDR_CMD && !refuse && !slot2) begin
        if (op == cch_pkg::OP_COLD_STEP && init_reg && !q_push) begin
          cold_reg <= arg_reg;
          konst_reg <= {16'h0000, arg_reg};
          date_reg[0] <= rtc_reg;
          count_reg[0] <= count_reg[0] + 16'h0001;
        end
        if (op == cch_pkg::OP_ZERO_CNT) begin
          count_reg[0] <= 16'h0000;
        end
        if (op == cch_pkg::OP_SAVE) begin
          nv_write_reg <= 1'b1;
          nv_data_reg <= konst_reg;
        end
      end
    end
  end
  assign nv_write = nv_write_reg;
  assign nv_data = nv_data_reg;
  assign cold_temp = cold_reg;

  // Query response latch.
  always_ff @(posedge mclk) begin
    if (rst) begin
      resp_reg <= 32'h0000_0000;
    end else if (wr_en && paddr == cch_pkg::ADDR_CMD) begin
      unique case (op)
        cch_pkg::OP_DATE_Q: resp_reg <= date_reg[slot2];
        cch_pkg::OP_COUNT_Q: resp_reg <= {16'h0000, count_reg[slot2]};
        cch_pkg::OP_LOCK_Q: resp_reg <= {31'h0, unlock_reg};
        default: ;
      endcase
    end
  end

  // Read data, combinational during the access phase.
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        cch_pkg::ADDR_STATUS: prdata = {24'h0, stb};
        cch_pkg::ADDR_ERR: prdata = {22'h0, q_head};
        cch_pkg::ADDR_SRE: prdata = {24'h0, sre_reg};
        cch_pkg::ADDR_RESP: prdata = resp_reg;
        cch_pkg::ADDR_ARG: prdata = {16'h0, arg_reg};
        cch_pkg::ADDR_RTC: prdata = rtc_reg;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule // cch_handler
`default_nettype wire

// ### bench/cch_nv_store.sv
// Model of the card nonvolatile store that takes saved constants.
`default_nettype none
module cch_nv_store (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Store side.
  input wire logic nv_write,
  input wire logic [31:0] nv_data,
  output logic [7:0] save_cnt,
  output logic [31:0] kept
);
  timeunit 1ns;
  timeprecision 1ps;
  // Only a save pulse changes what the card keeps.
  always_ff @(posedge mclk) begin
    if (rst) begin
      save_cnt <= 8'h00;
    end else if (nv_write) begin
      save_cnt <= save_cnt + 8'h01;
      kept <= nv_data;
    end
  end
endmodule // cch_nv_store
`default_nettype wire

// ### bench/cch_chk.sv
// Checker of the command handler port behaviour.
`default_nettype none
module cch_chk (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Bus side.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs.
  input wire logic srq,
  input wire logic nv_write,
  input wire logic [31:0] nv_data,
  input wire logic [15:0] cold_temp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sre_q;
  logic acc;
  logic wcmd;
  logic rsts;
  assign acc = psel && penable;
  assign wcmd = acc && pwrite && paddr == cch_pkg::ADDR_CMD;
  assign rsts = acc && !pwrite && paddr == cch_pkg::ADDR_STATUS;
  // Shadow of the service request enable.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sre_q <= 8'h00;
    end else if (acc && pwrite && paddr == cch_pkg::ADDR_SRE) begin
      sre_q <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ready; acc |-> pready && !pslverr; endproperty
  a_ready: assert property (p_ready) else $error("bus answer bad");
  property p_idle; !acc |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_rqs; rsts |-> prdata[6] == srq; endproperty
  a_rqs: assert property (p_rqs) else $error("rqs bit wrong");
  property p_srq; rsts |-> srq == |(prdata[7:0] & sre_q & 8'hBF); endproperty
  a_srq: assert property (p_srq) else $error("srq wrong");
  property p_pulse; nv_write |=> !nv_write; endproperty
  a_pulse: assert property (p_pulse) else $error("save pulse long");
  property p_save;
    $rose(nv_write) |-> $past(wcmd && pwdata[4:0] == 5'h06);
  endproperty
  a_save: assert property (p_save) else $error("save cause");
  property p_cold; $changed(cold_temp) |-> $past(wcmd); endproperty
  a_cold: assert property (p_cold) else $error("cold temp cause");
  property p_rst; $fell(rst) |-> !srq && !nv_write && cold_temp == 16'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_stay; !wcmd ##1 !wcmd |-> $stable(cold_temp); endproperty
  a_stay: assert property (p_stay) else $error("cold temp drift");
endmodule // cch_chk
bind cch_handler cch_chk cch_chk_inst (.mclk(mclk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .srq(srq), .nv_write(nv_write), .nv_data(nv_data),
  .cold_temp(cold_temp));
`default_nettype wire

// ### bench/testbench.sv
// Testbench of the card calibration command handler.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, srq, nv_write;
  logic [7:0] paddr, save_cnt;
  logic [31:0] pwdata, prdata, nv_data, kept, rd;
  logic [15:0] cold_temp;
  logic [9:0] codes [14];
  int error_cnt, n_tests, cyc, i, b;
  cch_handler cch_handler_inst (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .srq(srq),
    .nv_write(nv_write), .nv_data(nv_data), .cold_temp(cold_temp));
  cch_nv_store cch_nv_store_inst (.mclk(mclk), .rst(rst),
    .nv_write(nv_write), .nv_data(nv_data), .save_cnt(save_cnt),
    .kept(kept));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task give_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task cmd(input logic [3:0] op);
    apb(1'b1, cch_pkg::ADDR_CMD, {28'h0, op});
  endtask
  task query(input logic [3:0] op, input logic [31:0] exp);
    cmd(op);
    apb(1'b0, cch_pkg::ADDR_RESP, 32'h0);
    chk(rd, exp);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict;
    end
  end
  initial begin
    codes = '{cch_pkg::ERR_DCV_LO, cch_pkg::ERR_DCV_HI,
      cch_pkg::ERR_NO_DATE, cch_pkg::ERR_NO_NEXT, cch_pkg::ERR_AC_LO,
      cch_pkg::ERR_AC_HI, cch_pkg::ERR_COLD, cch_pkg::ERR_INVALID,
      cch_pkg::ERR_AC_LOST, cch_pkg::ERR_DC_LOST, cch_pkg::ERR_DATES_LOST,
      cch_pkg::ERR_CARD_LOST, cch_pkg::ERR_CARD_DATES,
      cch_pkg::ERR_QUESTION};
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    query(cch_pkg::OP_LOCK_Q, 32'h0);
    cmd(cch_pkg::OP_SAVE);
    @(posedge mclk);
    chk({24'h0, save_cnt}, 32'h0);
    rdchk(cch_pkg::ADDR_STATUS, 32'h4);
    rdchk(cch_pkg::ADDR_ERR, {22'h0, cch_pkg::ERR_LOCKED});
    rdchk(cch_pkg::ADDR_STATUS, 32'h0);
    apb(1'b1, cch_pkg::ADDR_CODE_LO, 32'h3030_3030);
    apb(1'b1, cch_pkg::ADDR_CODE_HI, 32'h4341_4C30);
    cmd(cch_pkg::OP_CODE);
    query(cch_pkg::OP_LOCK_Q, 32'h1);
    apb(1'b1, cch_pkg::ADDR_RTC, 32'h07D5_0A1C);
    cmd(cch_pkg::OP_INIT);
    apb(1'b1, cch_pkg::ADDR_ARG, 32'h17);
    cmd(cch_pkg::OP_COLD_STEP);
    chk({16'h0, cold_temp}, 32'h17);
    apb(1'b1, cch_pkg::ADDR_ARG, 32'h40);
    cmd(cch_pkg::OP_COLD_STEP);
    chk({16'h0, cold_temp}, 32'h17);
    rdchk(cch_pkg::ADDR_ERR, {22'h0, cch_pkg::ERR_COLD});
    query(cch_pkg::OP_DATE_Q, 32'h07D5_0A1C);
    apb(1'b1, cch_pkg::ADDR_CMD, 32'h15);
    rdchk(cch_pkg::ADDR_RESP, 32'h0);
    query(cch_pkg::OP_COUNT_Q, 32'h1);
    cmd(cch_pkg::OP_ZERO_CNT);
    query(cch_pkg::OP_COUNT_Q, 32'h0);
    cmd(cch_pkg::OP_SAVE);
    @(posedge mclk);
    chk({24'h0, save_cnt}, 32'h1);
    chk(kept, 32'h17);
    cmd(cch_pkg::OP_LOCK);
    query(cch_pkg::OP_LOCK_Q, 32'h0);
    apb(1'b1, cch_pkg::ADDR_ARG, 32'h5);
    cmd(cch_pkg::OP_COLD_STEP);
    chk({16'h0, cold_temp}, 32'h17);
    rdchk(cch_pkg::ADDR_ERR, {22'h0, cch_pkg::ERR_LOCKED});
    apb(1'b1, cch_pkg::ADDR_SRE, 32'h4);
    for (b = 0; b < 14; b += 7) begin
      for (i = b; i < b + 7; i++) begin
        apb(1'b1, cch_pkg::ADDR_CALERR, {22'h0, codes[i]});
      end
      rdchk(cch_pkg::ADDR_STATUS, 32'h44);
      chk({31'h0, srq}, 32'h1);
      for (i = b; i < b + 7; i++) begin
        rdchk(cch_pkg::ADDR_ERR, {22'h0, codes[i]});
      end
      rdchk(cch_pkg::ADDR_STATUS, 32'h0);
    end
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
